// [rtl/sapc_pkg.sv]
// package of constants and types for the scroll area and pump command logic
// Behaviour
// R1 - host keeps off display memory while scrolling
// R2 - host leaves scroll setup alone while scrolling
// R3 - vertical area command takes three bytes
// R4 - scrolling rows not above row multiplex ratio
// R5 - frame = osc / (divide * row clocks * 64)
// R6 - reset: divide one, row period 54 clocks
// R7 - pump command 8D, parameter bit 2 enables
// R8 - host sends 8D, 14h, then display on
// R9 - command select low means command write
// R10 - host reprograms command registers after reset
// R11 - activate scroll uses latest setup parameters
// R12 - deactivate scroll halts scrolling motion
// R13 - multi-byte settings apply after final byte
package sapc_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] SAPC_OFS_BYTE = 8'h00; // command/data byte entry
  localparam logic [7:0] SAPC_OFS_STAT = 8'h04; // state and sticky flags
  localparam logic [7:0] SAPC_OFS_AREA = 8'h08; // vertical area and timing
  // byte entry fields
  localparam int SAPC_BYTE_DC_POS = 8; // 0 command, 1 display data
  // status fields
  localparam int SAPC_ST_SCROLL_POS = 0;
  localparam int SAPC_ST_SETUP_POS = 1;
  localparam int SAPC_ST_PUMPSEL_POS = 2;
  localparam int SAPC_ST_DISP_POS = 3;
  localparam int SAPC_ST_PUMPON_POS = 4;
  localparam int SAPC_ST_BUSY_POS = 5;
  localparam int SAPC_ST_RAMERR_POS = 8;
  localparam int SAPC_ST_SETERR_POS = 9;
  localparam int SAPC_ST_AREAERR_POS = 10;
  // area register fields
  localparam int SAPC_AR_FIX_POS = 0;
  localparam int SAPC_AR_ROWS_POS = 8;
  localparam int SAPC_AR_DIV_POS = 16;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SAPC_CMD_SCROLL_OFF = 8'h2e;
  localparam logic [7:0] SAPC_CMD_SCROLL_ON = 8'h2f;
  localparam logic [7:0] SAPC_CMD_VAREA = 8'ha3;
  localparam logic [7:0] SAPC_CMD_PUMP = 8'h8d;
  localparam logic [7:0] SAPC_CMD_DISP_ON = 8'haf;
  localparam logic [7:0] SAPC_CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] SAPC_CMD_CLKDIV = 8'hd5;
  localparam logic [7:0] SAPC_CMD_HS_R = 8'h26;
  localparam logic [7:0] SAPC_CMD_HS_L = 8'h27;
  localparam logic [7:0] SAPC_CMD_VHS_R = 8'h29;
  localparam logic [7:0] SAPC_CMD_VHS_L = 8'h2a;
  localparam logic [2:0] SAPC_NPAR_HS = 3'h6; // horizontal setup parameters
  localparam logic [2:0] SAPC_NPAR_VHS = 3'h5; // diagonal setup parameters
  localparam logic [2:0] SAPC_NPAR_VAREA = 3'h2; // area command parameters
  localparam logic [2:0] SAPC_NPAR_ONE = 3'h1; // pump and divider
  localparam int SAPC_PUMP_EN_BIT = 2;
  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] SAPC_RST_DIV = 5'h01; // divide ratio after reset
  localparam logic [5:0] SAPC_ROW_CLKS = 6'h36; // 54 display clocks per row
  localparam logic [6:0] SAPC_FRAME_ROWS = 7'h40; // 64 rows per frame
  localparam logic [6:0] SAPC_RST_MUX = 7'h40; // default row multiplex ratio
  localparam logic [6:0] SAPC_RST_VROWS = 7'h40;
  localparam logic [5:0] SAPC_RST_VFIX = 6'h00;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SAPC_IDLE = 2'b01, // waiting for a command code
    SAPC_PARAM = 2'b10 // collecting parameter bytes
  } sapc_state_e;
endpackage

// [rtl/sapc_top.sv]
// command interpreter for scrolling, vertical area, frame timing and pump
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
module sapc_top #(
  parameter logic [6:0] ROW_MUX = sapc_pkg::SAPC_RST_MUX // row multiplex ratio
) (
  input wire logic CLK_SYS_I, // 100 MHz clock, also the display oscillator
  input wire logic RESETN_I, // asynchronous reset, active low
  input wire logic HSEL_I, // slave select
  input wire logic [31:0] HADDR_I, // byte address
  input wire logic [1:0] HTRANS_I, // transfer type
  input wire logic HWRITE_I, // write when high
  input wire logic [2:0] HSIZE_I, // word transfers only
  input wire logic HREADY_I, // bus ready
  input wire logic [31:0] HWDATA_I, // write data
  output logic HREADYOUT_O, // ready from one clock after the synchronised reset releases, then always
  output logic HRESP_O, // always OKAY
  output logic [31:0] HRDATA_O, // read data
  output logic SCROLL_ACTIVE_O, // scrolling motion running
  output logic PUMP_ON_O, // charge pump running
  output logic FRAME_TICK_O // one-cycle pulse per frame
);
  import sapc_pkg::*;

  // refused at elaboration: the area limit cannot exceed the rows of a frame
  if (ROW_MUX == 7'h00 || ROW_MUX > SAPC_FRAME_ROWS) begin : g_mux_check
    $error("ROW_MUX out of range");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg; // two-stage release of the reset
  logic rst_n; // synchronised reset used by the rest of the block
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sapc_state_e state; // command parser state
    logic [7:0] opcode; // command collecting parameters
    logic [2:0] left; // parameter bytes still due
    logic [7:0] p0; // first parameter held until the last arrives
    logic scroll; // scrolling active
    logic setup; // a scroll setup has completed
    logic pump_sel; // pump enable setting
    logic disp; // display on
    logic pump_on; // pump running
    logic [5:0] vfix; // fixed top rows
    logic [6:0] vrows; // rows in the scroll area
    logic [4:0] div; // clock divide ratio, 1 to 16
    logic ram_err; // display data sent while scrolling
    logic set_err; // scroll setup sent while scrolling
    logic area_err; // area rows above row multiplex ratio
    logic [4:0] dcnt; // oscillator clocks within a display clock
    logic [5:0] kcnt; // display clocks within a row
    logic [6:0] rcnt; // rows within a frame
    logic frame; // frame pulse
    logic wr_pend; // write data phase pending
    logic [7:0] addr; // latched address of the write
    logic [31:0] rdata; // read data for the data phase
    logic ready; // bus ready out
    logic resp; // bus response, kept in a flop so the output is registered
  } sapc_s;

  sapc_s st_reg;
  sapc_s st_next;

  // parameter count that follows a command code, zero for single bytes
  function automatic logic [2:0] npar(input logic [7:0] code);
    if (code == SAPC_CMD_HS_R || code == SAPC_CMD_HS_L) begin
      npar = SAPC_NPAR_HS;
    end else if (code == SAPC_CMD_VHS_R || code == SAPC_CMD_VHS_L) begin
      npar = SAPC_NPAR_VHS;
    end else if (code == SAPC_CMD_VAREA) begin
      npar = SAPC_NPAR_VAREA;
    end else if (code == SAPC_CMD_PUMP || code == SAPC_CMD_CLKDIV) begin
      npar = SAPC_NPAR_ONE;
    end else begin
      npar = 3'h0;
    end
  endfunction

  // horizontal or diagonal scroll setup code
  function automatic logic is_setup(input logic [7:0] code);
    is_setup = (npar(code) == SAPC_NPAR_HS) || (npar(code) == SAPC_NPAR_VHS);
  endfunction

  logic addr_ph; // address phase accepted this cycle
  logic byte_wr; // a byte is written into the entry register
  logic stat_wr; // a write to the status register
  logic [7:0] wbyte; // the byte written
  logic wdc; // its command select
  logic last; // final parameter byte of the command

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    addr_ph = HSEL_I && HTRANS_I[1] && HREADY_I;
    byte_wr = st_reg.wr_pend && (st_reg.addr == SAPC_OFS_BYTE);
    stat_wr = st_reg.wr_pend && (st_reg.addr == SAPC_OFS_STAT);
    wbyte = HWDATA_I[7:0];
    wdc = HWDATA_I[SAPC_BYTE_DC_POS];
    st_next.ready = 1'b1;
    st_next.resp = 1'b0; // every transfer answers OKAY
    st_next.wr_pend = addr_ph && HWRITE_I;
    st_next.frame = 1'b0;
    // write-one clears sticky flags; a new event below still wins
    if (stat_wr) begin
      if (HWDATA_I[SAPC_ST_RAMERR_POS]) st_next.ram_err = 1'b0;
      if (HWDATA_I[SAPC_ST_SETERR_POS]) st_next.set_err = 1'b0;
      if (HWDATA_I[SAPC_ST_AREAERR_POS]) st_next.area_err = 1'b0;
    end
    if (addr_ph) begin
      st_next.addr = HADDR_I[7:0];
    end
    // read data prepared at the address phase, zero where nothing is mapped
    st_next.rdata = 32'h0000_0000;
    if (addr_ph && !HWRITE_I) begin
      if (HADDR_I[7:0] == SAPC_OFS_STAT) begin
        st_next.rdata[SAPC_ST_SCROLL_POS] = st_reg.scroll;
        st_next.rdata[SAPC_ST_SETUP_POS] = st_reg.setup;
        st_next.rdata[SAPC_ST_PUMPSEL_POS] = st_reg.pump_sel;
        st_next.rdata[SAPC_ST_DISP_POS] = st_reg.disp;
        st_next.rdata[SAPC_ST_PUMPON_POS] = st_reg.pump_on;
        st_next.rdata[SAPC_ST_BUSY_POS] = (st_reg.state == SAPC_PARAM);
        st_next.rdata[SAPC_ST_RAMERR_POS] = st_reg.ram_err;
        st_next.rdata[SAPC_ST_SETERR_POS] = st_reg.set_err;
        st_next.rdata[SAPC_ST_AREAERR_POS] = st_reg.area_err;
      end else if (HADDR_I[7:0] == SAPC_OFS_AREA) begin
        st_next.rdata[SAPC_AR_FIX_POS +: 6] = st_reg.vfix;
        st_next.rdata[SAPC_AR_ROWS_POS +: 7] = st_reg.vrows;
        st_next.rdata[SAPC_AR_DIV_POS +: 5] = st_reg.div;
      end
    end
    last = (st_reg.left == 3'h1);
    // byte interpreter: command select low is a command write [R9]
    if (byte_wr && wdc) begin
      // display data while scrolling is dropped and flagged [R1]
      if (st_reg.scroll) st_next.ram_err = 1'b1;
    end else if (byte_wr) begin
      case (st_reg.state)
        SAPC_IDLE: begin
          if (npar(wbyte) != 3'h0) begin
            st_next.state = SAPC_PARAM;
            st_next.opcode = wbyte;
            st_next.left = npar(wbyte);
            // setup while scrolling is flagged and later discarded [R2]
            if (is_setup(wbyte) && st_reg.scroll) st_next.set_err = 1'b1;
          end else if (wbyte == SAPC_CMD_SCROLL_ON) begin
            st_next.scroll = st_reg.setup; // [R11]
          end else if (wbyte == SAPC_CMD_SCROLL_OFF) begin
            st_next.scroll = 1'b0; // [R12]
          end else if (wbyte == SAPC_CMD_DISP_ON) begin
            st_next.disp = 1'b1; // [R8]
          end else if (wbyte == SAPC_CMD_DISP_OFF) begin
            st_next.disp = 1'b0;
          end
        end
        SAPC_PARAM: begin
          st_next.left = st_reg.left - 3'h1;
          if (st_reg.left == npar(st_reg.opcode)) st_next.p0 = wbyte;
          if (last) begin
            st_next.state = SAPC_IDLE;
            // settings change only on the final byte [R13]
            if (st_reg.opcode == SAPC_CMD_VAREA) begin
              st_next.vfix = st_reg.p0[5:0]; // [R3]
              st_next.vrows = wbyte[6:0]; // [R3]
              if (wbyte[6:0] > ROW_MUX) st_next.area_err = 1'b1; // [R4]
            end else if (st_reg.opcode == SAPC_CMD_PUMP) begin
              st_next.pump_sel = wbyte[SAPC_PUMP_EN_BIT]; // [R7]
            end else if (st_reg.opcode == SAPC_CMD_CLKDIV) begin
              st_next.div = {1'b0, wbyte[3:0]} + 5'h01;
            end else if (!st_reg.scroll) begin
              st_next.setup = 1'b1; // latest setup replaces older [R11]
            end
          end
        end
        default: begin
          st_next.state = SAPC_IDLE;
        end
      endcase
    end
    // pump runs only with its enable set and the display on [R7]
    st_next.pump_on = st_reg.pump_sel && st_reg.disp;
    // frame timer: divide, then 54 clocks a row, then 64 rows [R5]
    st_next.dcnt = st_reg.dcnt + 5'h01;
    if (st_reg.dcnt + 5'h01 >= st_reg.div) begin
      st_next.dcnt = 5'h00;
      st_next.kcnt = st_reg.kcnt + 6'h01;
      if (st_reg.kcnt == SAPC_ROW_CLKS - 6'h01) begin
        st_next.kcnt = 6'h00;
        st_next.rcnt = st_reg.rcnt + 7'h01;
        if (st_reg.rcnt == SAPC_FRAME_ROWS - 7'h01) begin
          st_next.rcnt = 7'h00;
          st_next.frame = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= SAPC_IDLE;
      st_reg.div <= SAPC_RST_DIV; // [R6]
      st_reg.vrows <= SAPC_RST_VROWS;
      st_reg.vfix <= SAPC_RST_VFIX;
    end else begin
      st_reg <= st_next;
    end
  end

  assign HREADYOUT_O = st_reg.ready;
  assign HRESP_O = st_reg.resp;
  assign HRDATA_O = st_reg.rdata;
  assign SCROLL_ACTIVE_O = st_reg.scroll;
  assign PUMP_ON_O = st_reg.pump_on;
  assign FRAME_TICK_O = st_reg.frame;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!rst_n);

  chk_scroll_stop: assert property (byte_wr && !wdc && st_reg.state == SAPC_IDLE
    && wbyte == SAPC_CMD_SCROLL_OFF |=> !SCROLL_ACTIVE_O) // [R12]
    else $error("scroll did not stop");
  chk_scroll_start: assert property (byte_wr && !wdc && st_reg.state == SAPC_IDLE
    && wbyte == SAPC_CMD_SCROLL_ON |=> SCROLL_ACTIVE_O == $past(st_reg.setup)) // [R11]
    else $error("scroll start wrong");
  chk_ram_flag: assert property (byte_wr && wdc && st_reg.scroll |=> st_reg.ram_err) // [R1]
    else $error("data during scroll not flagged");
  chk_pump_out: assert property (st_reg.pump_sel && st_reg.disp |=> PUMP_ON_O) // [R7]
    else $error("pump not running");
  chk_pump_off: assert property (!st_reg.disp |=> !PUMP_ON_O) // [R7]
    else $error("pump runs with display off");
  chk_area_hold: assert property (st_reg.state == SAPC_PARAM && !last |=>
    $stable(st_reg.vrows) && $stable(st_reg.pump_sel)) // [R13]
    else $error("settings changed before final byte");
  chk_area_apply: assert property (byte_wr && !wdc && st_reg.state == SAPC_PARAM
    && last && st_reg.opcode == SAPC_CMD_VAREA |=> st_reg.vrows == $past(wbyte[6:0])) // [R3]
    else $error("area rows not applied");
  chk_area_err: assert property (st_reg.vrows > ROW_MUX && $changed(st_reg.vrows)
    |-> st_reg.area_err) // [R4]
    else $error("oversized area not flagged");
  // after a frame pulse, no further pulse for the next 8 clocks, whatever the divide ratio
  chk_frame_gap: assert property (FRAME_TICK_O |=> !FRAME_TICK_O [*8]) // [R5]
    else $error("frame ticks too close");
  chk_cmd_path: assert property (byte_wr && wdc |=> $stable(st_reg.state)) // [R9]
    else $error("data byte moved parser");
  chk_rst_div: assert property ($rose(rst_n) |-> st_reg.div == SAPC_RST_DIV) // [R6]
    else $error("divide ratio reset wrong");

  cov_scroll_on: cover property ($rose(SCROLL_ACTIVE_O));
  cov_pump_on: cover property ($rose(PUMP_ON_O));
  cov_frame: cover property (FRAME_TICK_O);
  cov_set_err: cover property ($rose(st_reg.set_err));
endmodule

// [bench/sapc_host.sv]
// host bus master model that issues command and display bytes
module sapc_host (
  input wire logic clk_i, // system clock
  input wire logic hready_i, // bus ready from the slave
  input wire logic [31:0] hrdata_i, // read data from the slave
  output logic hsel_o, // slave select
  output logic [31:0] haddr_o, // byte address
  output logic [1:0] htrans_o, // transfer type
  output logic hwrite_o, // write when high
  output logic [2:0] hsize_o, // always one word
  output logic [31:0] hwdata_o // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  import sapc_pkg::*;
  // ----------------------------------------------------------------
  // idle bus at time zero
  // ----------------------------------------------------------------
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end
  // one single word transfer; each phase is held until ready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    htrans_o <= 2'h2;
    haddr_o <= {24'h0, a};
    hwrite_o <= w;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= w ? d : 32'h0;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
  endtask
  // a byte entry; select low marks a command byte
  task automatic send(input logic [7:0] b, input logic dc);
    logic [31:0] q;
    xfer(1'b1, SAPC_OFS_BYTE, {23'h0, dc, b}, q);
  endtask
  // pump bring-up: setting code, enable parameter, then display on
  task automatic pump_start();
    send(SAPC_CMD_PUMP, 1'b0);
    send(8'h14, 1'b0);
    send(SAPC_CMD_DISP_ON, 1'b0);
  endtask
endmodule

// [bench/sapc_top_test.sv]
// self-checking testbench of the scroll area and pump command logic
module sapc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sapc_pkg::*;
  logic clk_sys = 1'b0; // 100 MHz clock
  logic resetn = 1'b0; // active low reset
  logic hsel, hwrite, hreadyout, hresp, scroll_on, pump_on, frame_tick;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int bad_count = 0;
  int checks = 0;
  always #5 clk_sys = ~clk_sys;
  sapc_host sapc_host_i (.clk_i(clk_sys), .hready_i(hreadyout), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));
  sapc_top sapc_top_i (.CLK_SYS_I(clk_sys), .RESETN_I(resetn), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HREADY_I(hreadyout), .HWDATA_I(hwdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .HRDATA_O(hrdata), .SCROLL_ACTIVE_O(scroll_on), .PUMP_ON_O(pump_on),
    .FRAME_TICK_O(frame_tick));
  // ----------------------------------------------------------------
  // compare and access helpers
  // ----------------------------------------------------------------
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic rd(input logic [7:0] a);
    sapc_host_i.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic cmd(input logic [7:0] b);
    sapc_host_i.send(b, 1'b0);
    repeat (3) @(negedge clk_sys);
  endtask
  function automatic logic [31:0] area(input logic [4:0] d, input logic [6:0] r,
                                        input logic [5:0] f);
    return (32'(d) << SAPC_AR_DIV_POS) | (32'(r) << SAPC_AR_ROWS_POS) | 32'(f);
  endfunction
  // cycles between two frame pulses, sampled away from the active edge
  task automatic period(output int n);
    int w;
    w = 0;
    n = 0;
    do begin @(negedge clk_sys); w++; end while (frame_tick !== 1'b1 && w < 20000);
    do begin @(negedge clk_sys); n++; end while (frame_tick !== 1'b1 && n < 20000);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    rd(SAPC_OFS_AREA);
    chk32("area", area(SAPC_RST_DIV, SAPC_RST_VROWS, SAPC_RST_VFIX), q);
    rd(SAPC_OFS_STAT);
    chk32("status", 32'h0, q);
    rd(8'h0c);
    chk32("unmapped", 32'h0, q);
    chk1("resp", 1'b0, hresp);
  endtask
  task automatic t_area();
    cmd(SAPC_CMD_VAREA);
    cmd(8'h05);
    rd(SAPC_OFS_STAT);
    chk1("collecting", 1'b1, q[SAPC_ST_BUSY_POS]);
    rd(SAPC_OFS_AREA);
    chk32("area partial", area(SAPC_RST_DIV, SAPC_RST_VROWS, 6'h00), q);
    cmd(8'h20);
    rd(SAPC_OFS_AREA);
    chk32("area set", area(SAPC_RST_DIV, 7'h20, 6'h05), q);
    cmd(SAPC_CMD_VAREA);
    cmd(8'h00);
    cmd(8'h41); // one row above the multiplex ratio
    rd(SAPC_OFS_STAT);
    chk1("area err", 1'b1, q[SAPC_ST_AREAERR_POS]);
    sapc_host_i.xfer(1'b1, SAPC_OFS_STAT, 32'h400, q);
    rd(SAPC_OFS_STAT);
    chk1("area err clr", 1'b0, q[SAPC_ST_AREAERR_POS]);
  endtask
  task automatic t_frame();
    int n;
    period(n);
    chk32("frame", 32'(SAPC_ROW_CLKS) * 32'(SAPC_FRAME_ROWS), n);
    cmd(SAPC_CMD_CLKDIV);
    cmd(8'h01); // divide by two
    period(n);
    period(n);
    chk32("frame div2", 32'h2 * 32'(SAPC_ROW_CLKS) * 32'(SAPC_FRAME_ROWS), n);
    rd(SAPC_OFS_AREA);
    chk32("div field", 32'h2, (q >> SAPC_AR_DIV_POS) & 32'h1f);
  endtask
  task automatic t_scroll();
    cmd(SAPC_CMD_SCROLL_ON);
    chk1("no setup", 1'b0, scroll_on);
    cmd(SAPC_CMD_HS_R);
    repeat (6) cmd(8'h00);
    rd(SAPC_OFS_STAT);
    chk1("setup done", 1'b1, q[SAPC_ST_SETUP_POS]);
    sapc_host_i.send(SAPC_CMD_SCROLL_ON, 1'b1); // display data, not a command
    repeat (3) @(negedge clk_sys);
    chk1("data not cmd", 1'b0, scroll_on);
    cmd(SAPC_CMD_SCROLL_ON);
    chk1("scroll on", 1'b1, scroll_on);
    sapc_host_i.send(8'h55, 1'b1);
    cmd(SAPC_CMD_HS_L);
    repeat (6) cmd(8'h01);
    rd(SAPC_OFS_STAT);
    chk1("ram err", 1'b1, q[SAPC_ST_RAMERR_POS]);
    chk1("setup err", 1'b1, q[SAPC_ST_SETERR_POS]);
    chk1("still on", 1'b1, scroll_on);
    cmd(SAPC_CMD_SCROLL_OFF);
    chk1("scroll off", 1'b0, scroll_on);
  endtask
  task automatic t_pump();
    cmd(SAPC_CMD_PUMP);
    cmd(8'h14);
    rd(SAPC_OFS_STAT);
    chk1("pump sel", 1'b1, q[SAPC_ST_PUMPSEL_POS]);
    chk1("pump idle", 1'b0, pump_on);
    cmd(SAPC_CMD_DISP_ON);
    chk1("pump run", 1'b1, pump_on);
    rd(SAPC_OFS_STAT);
    chk1("disp stat", 1'b1, q[SAPC_ST_DISP_POS]);
    chk1("pump stat", 1'b1, q[SAPC_ST_PUMPON_POS]);
    cmd(SAPC_CMD_PUMP);
    cmd(8'hd0); // bit 2 clear, don't-care bits set
    chk1("pump off", 1'b0, pump_on);
    sapc_host_i.pump_start();
    repeat (3) @(negedge clk_sys);
    chk1("pump again", 1'b1, pump_on);
    cmd(SAPC_CMD_DISP_OFF);
    chk1("pump disp off", 1'b0, pump_on);
  endtask
  // mid-run reset with scrolling, pump and a divide of two all active
  task automatic t_rereset();
    cmd(SAPC_CMD_SCROLL_ON);
    cmd(SAPC_CMD_DISP_ON);
    chk1("busy before rst", 1'b1, scroll_on & pump_on);
    resetn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk1("scroll rst", 1'b0, scroll_on);
    chk1("pump rst", 1'b0, pump_on);
    rd(SAPC_OFS_AREA);
    chk32("area rst", area(SAPC_RST_DIV, SAPC_RST_VROWS, SAPC_RST_VFIX), q);
    rd(SAPC_OFS_STAT);
    chk32("status rst", 32'h0, q);
  endtask
  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys); // let the reset synchroniser and ready settle
    t_reset_vals();
    t_area();
    t_frame();
    t_scroll();
    t_pump();
    t_rereset();
    finish_test();
  end
endmodule
